// ==== dv/dpram_checker.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checks; outside device reset the memory outputs may only move on enabled edges.
// ---------------------------------------------------------------
module dpram_checker #(
    parameter A_WIDTH = 16,
    parameter B_WIDTH = 16,
    parameter A_AW    = 8,
    parameter B_AW    = 8
) (
    // Watched pins only, grouped by port.
    input wire               clk_in, sys_rst_in,
    input wire               port_a_en_in, port_a_we_in, port_a_rst_in,
    input wire [A_AW-1:0]    port_a_addr_in,
    input wire [A_WIDTH-1:0] port_a_write_data_in, port_a_read_data_out,
    input wire               port_b_en_in, port_b_we_in, port_b_rst_in,
    input wire [B_AW-1:0]    port_b_addr_in,
    input wire [B_WIDTH-1:0] port_b_write_data_in, port_b_read_data_out
);
    localparam RATIO = B_WIDTH / A_WIDTH; // Narrow units per wide word.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_a_hold;
        !port_a_en_in |=> $stable(port_a_read_data_out);
    endproperty
    property p_b_hold;
        !port_b_en_in |=> $stable(port_b_read_data_out);
    endproperty
    property p_a_wr;
        port_a_en_in && port_a_we_in && !port_a_rst_in |=>
            port_a_read_data_out == $past(port_a_write_data_in);
    endproperty
    property p_b_wr;
        port_b_en_in && port_b_we_in && !port_b_rst_in |=>
            port_b_read_data_out == $past(port_b_write_data_in);
    endproperty
    property p_a_clr;
        port_a_en_in && port_a_rst_in |=> port_a_read_data_out == '0;
    endproperty
    property p_b_clr;
        port_b_en_in && port_b_rst_in |=> port_b_read_data_out == '0;
    endproperty
    // The device reset must clear both outputs, so it is not disabled.
    property p_sys_clr;
        disable iff (1'b0) sys_rst_in |=>
            port_a_read_data_out == '0 && port_b_read_data_out == '0;
    endproperty
    // A wide write read back through the narrow port on the next edge.
    sequence s_wide_then_narrow;
        port_b_en_in && port_b_we_in && !port_b_rst_in ##1
        port_a_en_in && !port_a_we_in && !port_a_rst_in &&
        port_a_addr_in / RATIO == $past(port_b_addr_in);
    endsequence
    property p_xwidth;
        s_wide_then_narrow |=> port_a_read_data_out == A_WIDTH'(
            $past(port_b_write_data_in, 2) >>
            ($past(port_a_addr_in) % RATIO * A_WIDTH));
    endproperty
    a_a_hold: assert property (p_a_hold) else $error("a moved");
    a_b_hold: assert property (p_b_hold) else $error("b moved");
    a_a_wr: assert property (p_a_wr) else $error("a no mirror");
    a_b_wr: assert property (p_b_wr) else $error("b no mirror");
    a_a_clr: assert property (p_a_clr) else $error("a not clr");
    a_b_clr: assert property (p_b_clr) else $error("b not clr");
    a_sys_clr: assert property (p_sys_clr) else $error("rst");
    a_xwidth: assert property (p_xwidth) else $error("map");
    c_a_rd: cover property (port_a_en_in && !port_a_we_in);
    c_b_wr: cover property (port_b_en_in && port_b_we_in);
    c_a_clr: cover property (port_a_en_in && port_a_rst_in);
endmodule
bind dpram_core dpram_checker #(.A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH),
    .A_AW(A_AW), .B_AW(B_AW)) u_chk (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .port_a_en_in(port_a_en_in),
    .port_a_we_in(port_a_we_in), .port_a_rst_in(port_a_rst_in),
    .port_a_addr_in(port_a_addr_in),
    .port_a_write_data_in(port_a_write_data_in),
    .port_a_read_data_out(port_a_read_data_out),
    .port_b_en_in(port_b_en_in), .port_b_we_in(port_b_we_in),
    .port_b_rst_in(port_b_rst_in), .port_b_addr_in(port_b_addr_in),
    .port_b_write_data_in(port_b_write_data_in),
    .port_b_read_data_out(port_b_read_data_out));

// ==== dv/dpram_user.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// User logic on one port; idle address and data lines are scrambled, not held.
// ---------------------------------------------------------------
module dpram_user #(
    parameter W  = 16,
    parameter AW = 8
) (
    // Request lines towards the memory port.
    output logic          en_out,
    output logic          we_out,
    output logic          rst_out,
    output logic [AW-1:0] addr_out,
    output logic [W-1:0]  data_out
);
    initial {en_out, we_out, rst_out, addr_out, data_out} = '0;
    // Called just after an edge; the lines stand until the next call.
    task automatic put(input logic e, w, r, input logic [AW-1:0] a,
                       input logic [W-1:0] d);
        en_out = e;
        we_out = w;
        rst_out = r;
        addr_out = e ? a : ~addr_out;
        data_out = e ? d : ~data_out;
    endtask
endmodule

// ==== dv/test_dual_port_block_ram.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port A at 4 bits, port B at 16 bits, so widths are mixed.
// ---------------------------------------------------------------
module test_dual_port_block_ram;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    wire         a_en, a_we, a_rst, b_en, b_we, b_rst;
    wire [9:0]   a_ad;
    wire [7:0]   b_ad;
    wire [3:0]   a_wd, a_rd;
    wire [15:0]  b_wd, b_rd;
    logic [15:0] sh [256]; // Shadow of the array, one word per B address.
    logic [3:0]  ea;       // Expected port outputs.
    logic [15:0] eb;
    logic [9:0]  aa;
    logic [7:0]  ba;
    int          bad_count = 0;
    int          compares = 0;
    int          seed;
    initial forever #2.5 clk_in = ~clk_in;
    dpram_core #(.A_WIDTH(4), .B_WIDTH(16)) DUT (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .port_a_en_in(a_en), .port_a_we_in(a_we),
        .port_a_rst_in(a_rst), .port_a_addr_in(a_ad),
        .port_a_write_data_in(a_wd), .port_a_read_data_out(a_rd),
        .port_b_en_in(b_en), .port_b_we_in(b_we), .port_b_rst_in(b_rst),
        .port_b_addr_in(b_ad), .port_b_write_data_in(b_wd),
        .port_b_read_data_out(b_rd));
    dpram_user #(.W(4), .AW(10)) ua (.en_out(a_en), .we_out(a_we),
        .rst_out(a_rst), .addr_out(a_ad), .data_out(a_wd));
    dpram_user ub (.en_out(b_en), .we_out(b_we),
        .rst_out(b_rst), .addr_out(b_ad), .data_out(b_wd));
    // Narrow view of the shadow: nibble a[1:0] of word a[9:2].
    function automatic logic [3:0] rd_a(input logic [9:0] a);
        return sh[a[9:2]][a[1:0]*4 +: 4];
    endfunction
    task automatic chk(input string n, input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Checks the previous edge, then issues one request on each port.
    task automatic step(input logic ae, aw, ar, input logic [9:0] a,
                        input logic [3:0] ad, input logic be, bw, br,
                        input logic [7:0] b, input logic [15:0] bd);
        @(posedge clk_in);
        #1;
        chk("port_a_out", {12'h000, a_rd}, {12'h000, ea});
        chk("port_b_out", b_rd, eb);
        if (ae) ea = ar ? 4'h0 : aw ? ad : rd_a(a);
        if (be) eb = br ? 16'h0000 : bw ? bd : sh[b];
        if (ae && aw) sh[a[9:2]][a[1:0]*4 +: 4] = ad;
        if (be && bw) sh[b] = bd;
        ua.put(ae, aw, ar, a, ad);
        ub.put(be, bw, br, b, bd);
    endtask
    // Mid-run device reset; the array keeps its contents.
    task automatic sysrst;
        step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        sys_rst_in = 1'b1;
        @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        ea = 4'h0;
        eb = 16'h0000;
    endtask
    initial begin
        seed = $urandom(32'h870B);
        ea = 4'h0;
        eb = 16'h0000;
        repeat (4) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        // Fill every word back to back, so no read meets unknown cells.
        for (int i = 0; i < 256; i++)
            step(0, 0, 0, 0, 0, 1, 1, 0, 8'(i), 16'($urandom));
        step(1, 1, 0, 10'h00F, 4'hA, 0, 0, 0, 0, 0);
        step(1, 0, 0, 10'h00F, 0, 1, 0, 0, 8'h03, 0);
        step(0, 1, 0, 10'h3FF, 4'h5, 0, 1, 0, 8'h03, 16'hFFFF);
        step(1, 1, 1, 10'h00E, 4'h6, 1, 0, 1, 8'h03, 0);
        step(1, 0, 0, 10'h00E, 0, 1, 1, 0, 8'h05, 16'h1234);
        step(1, 0, 0, 10'h016, 0, 0, 0, 0, 0, 0);
        for (int i = 0; i < 400; i++) begin
            aa = 10'($urandom);
            ba = 8'($urandom);
            if (ba == aa[9:2]) ba = ba + 8'h01;
            step($urandom % 4 != 0, 1'($urandom), $urandom % 8 == 0, aa,
                 4'($urandom), $urandom % 4 != 0, 1'($urandom),
                 $urandom % 8 == 0, ba, 16'($urandom));
            if (i == 200) sysrst();
        end
        step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        tally_and_finish();
    end
    // The run takes about 700 cycles; 3000 leaves ample margin.
    initial begin
        #(5.0 * 3000);
        bad_count++;
        tally_and_finish();
    end
endmodule

// ==== rtl/dpram_core.v ====
`timescale 1ns/1ps
`include "dpram_defines.vh"

// Dual-port block memory top. Both ports run on clk_in; every input is
// taken on its rising edge and every output is a flip-flop.
module dpram_core #(
    parameter A_WIDTH = `DPRAM_DEF_WIDTH,
    parameter B_WIDTH = `DPRAM_DEF_WIDTH,
    parameter A_MODE  = `DPRAM_MODE_RW,
    parameter B_MODE  = `DPRAM_MODE_RW,
    // Derived; do not override.
    parameter A_LW    = (A_WIDTH > 8) ? 4 : (A_WIDTH > 4) ? 3 :
                        (A_WIDTH > 2) ? 2 : (A_WIDTH > 1) ? 1 : 0,
    parameter B_LW    = (B_WIDTH > 8) ? 4 : (B_WIDTH > 4) ? 3 :
                        (B_WIDTH > 2) ? 2 : (B_WIDTH > 1) ? 1 : 0,
    parameter A_AW    = `DPRAM_CELL_AW - A_LW,
    parameter B_AW    = `DPRAM_CELL_AW - B_LW
) (
    // Clock and device reset.
    input  wire               clk_in,
    input  wire               sys_rst_in,
    // Port A controls.
    input  wire               port_a_en_in,
    input  wire               port_a_we_in,
    input  wire               port_a_rst_in,
    input  wire [A_AW-1:0]    port_a_addr_in,
    input  wire [A_WIDTH-1:0] port_a_write_data_in,
    // Port A data out.
    output wire [A_WIDTH-1:0] port_a_read_data_out,
    // Port B controls.
    input  wire               port_b_en_in,
    input  wire               port_b_we_in,
    input  wire               port_b_rst_in,
    input  wire [B_AW-1:0]    port_b_addr_in,
    input  wire [B_WIDTH-1:0] port_b_write_data_in,
    // Port B data out.
    output wire [B_WIDTH-1:0] port_b_read_data_out
);

    // -----------------------------------------------------------------
    // Decoded port A strobes and location
    // -----------------------------------------------------------------
    wire                      a_wr;     // Enabled write this edge.
    wire                      a_rd;     // Enabled read this edge.
    wire                      a_clr;    // Enabled output reset.
    wire [`DPRAM_WORD_AW-1:0] a_word;   // Storage word index.
    wire [`DPRAM_WORD_LW-1:0] a_off;    // Lane offset in that word.
    wire [`DPRAM_WORD_W-1:0]  a_mask;   // Bits written in the word.
    wire [`DPRAM_WORD_W-1:0]  a_wdata;  // Data placed on its lane.

    // -----------------------------------------------------------------
    // Decoded port B strobes and location
    // -----------------------------------------------------------------
    wire                      b_wr;     // Enabled write this edge.
    wire                      b_rd;     // Enabled read this edge.
    wire                      b_clr;    // Enabled output reset.
    wire [`DPRAM_WORD_AW-1:0] b_word;   // Storage word index.
    wire [`DPRAM_WORD_LW-1:0] b_off;    // Lane offset in that word.
    wire [`DPRAM_WORD_W-1:0]  b_mask;   // Bits written in the word.
    wire [`DPRAM_WORD_W-1:0]  b_wdata;  // Data placed on its lane.

    // -----------------------------------------------------------------
    // Port decoders
    // -----------------------------------------------------------------
    // Widths map onto the shared cells by the address times width rule,
    // so a narrow port and a wide port see the same bits.
    // The width pairing 1x4096 ... 16x256 falls out of A_LW and A_AW.
    dpram_port #(
        .WIDTH (A_WIDTH),
        .LW    (A_LW),
        .AW    (A_AW),
        .MODE  (A_MODE)
    ) u_port_a (
        .addr_in   (port_a_addr_in),
        .data_in   (port_a_write_data_in),
        .en_in     (port_a_en_in),
        .we_in     (port_a_we_in),
        .rst_in    (port_a_rst_in),
        .wr_out    (a_wr),
        .rd_out    (a_rd),
        .clr_out   (a_clr),
        .word_out  (a_word),
        .off_out   (a_off),
        .mask_out  (a_mask),
        .wdata_out (a_wdata)
    );

    // Port B decoder; it shares nothing with port A, so no arbitration
    // exists. Same-cell collisions are the user's to avoid.
    dpram_port #(
        .WIDTH (B_WIDTH),
        .LW    (B_LW),
        .AW    (B_AW),
        .MODE  (B_MODE)
    ) u_port_b (
        .addr_in   (port_b_addr_in),
        .data_in   (port_b_write_data_in),
        .en_in     (port_b_en_in),
        .we_in     (port_b_we_in),
        .rst_in    (port_b_rst_in),
        .wr_out    (b_wr),
        .rd_out    (b_rd),
        .clr_out   (b_clr),
        .word_out  (b_word),
        .off_out   (b_off),
        .mask_out  (b_mask),
        .wdata_out (b_wdata)
    );

    // -----------------------------------------------------------------
    // Shared array and output registers
    // -----------------------------------------------------------------
    // Every access finishes on one edge: the output register loads in
    // the same edge that writes the array. Outputs only move on clk_in,
    // which keeps them glitch-free and free of any address-to-output
    // combinational path. Port A is expected no wider than port B; the
    // logic itself works for either order.
    dpram_mem #(
        .A_WIDTH (A_WIDTH),
        .B_WIDTH (B_WIDTH)
    ) u_mem (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .a_wr_in    (a_wr),
        .a_rd_in    (a_rd),
        .a_clr_in   (a_clr),
        .a_word_in  (a_word),
        .a_off_in   (a_off),
        .a_mask_in  (a_mask),
        .a_wdata_in (a_wdata),
        .a_data_in  (port_a_write_data_in),
        .a_dout_q   (port_a_read_data_out),
        .b_wr_in    (b_wr),
        .b_rd_in    (b_rd),
        .b_clr_in   (b_clr),
        .b_word_in  (b_word),
        .b_off_in   (b_off),
        .b_mask_in  (b_mask),
        .b_wdata_in (b_wdata),
        .b_data_in  (port_b_write_data_in),
        .b_dout_q   (port_b_read_data_out)
    );

endmodule

// ==== rtl/dpram_defines.vh ====
`ifndef DPRAM_DEFINES_VH
`define DPRAM_DEFINES_VH

// ---------------------------------------------------------------------
// Shared array geometry
// ---------------------------------------------------------------------
// Total bit cells shared by both ports.
`define DPRAM_CELLS       4096
// Address bits needed for one-bit-wide access to all cells.
`define DPRAM_CELL_AW     12
// The array is stored as words of the widest port width.
`define DPRAM_WORD_W      16
// Log2 of the storage word width.
`define DPRAM_WORD_LW     4
// Number of storage words and their address width.
`define DPRAM_WORDS       256
`define DPRAM_WORD_AW     8

// ---------------------------------------------------------------------
// Port direction modes
// ---------------------------------------------------------------------
`define DPRAM_MODE_W      2
`define DPRAM_MODE_RW     2'h0
`define DPRAM_MODE_RO     2'h1
`define DPRAM_MODE_WO     2'h2

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
// Output register value after any reset.
`define DPRAM_DOUT_RST    16'h0000
// Default port width.
`define DPRAM_DEF_WIDTH   16

`endif

// ==== rtl/dpram_mem.v ====
`timescale 1ns/1ps
`include "dpram_defines.vh"

// Shared storage with two write lanes and two registered read lanes.
// The read register of each lane is that port's data output register.
module dpram_mem #(
    parameter A_WIDTH = `DPRAM_DEF_WIDTH,
    parameter B_WIDTH = `DPRAM_DEF_WIDTH
) (
    // Clock and device reset.
    input  wire                       clk_in,
    input  wire                       sys_rst_in,
    // Port A lane.
    input  wire                       a_wr_in,
    input  wire                       a_rd_in,
    input  wire                       a_clr_in,
    input  wire [`DPRAM_WORD_AW-1:0]  a_word_in,
    input  wire [`DPRAM_WORD_LW-1:0]  a_off_in,
    input  wire [`DPRAM_WORD_W-1:0]   a_mask_in,
    input  wire [`DPRAM_WORD_W-1:0]   a_wdata_in,
    input  wire [A_WIDTH-1:0]         a_data_in,
    output reg  [A_WIDTH-1:0]         a_dout_q,
    // Port B lane.
    input  wire                       b_wr_in,
    input  wire                       b_rd_in,
    input  wire                       b_clr_in,
    input  wire [`DPRAM_WORD_AW-1:0]  b_word_in,
    input  wire [`DPRAM_WORD_LW-1:0]  b_off_in,
    input  wire [`DPRAM_WORD_W-1:0]   b_mask_in,
    input  wire [`DPRAM_WORD_W-1:0]   b_wdata_in,
    input  wire [B_WIDTH-1:0]         b_data_in,
    output reg  [B_WIDTH-1:0]         b_dout_q
);

    // The 4096 cells, kept as 256 words of 16 bits.
    reg [`DPRAM_WORD_W-1:0] mem_q [0:`DPRAM_WORDS-1];

    // Word read back for each lane, shifted down to the port lane.
    wire [`DPRAM_WORD_W-1:0] a_rword = mem_q[a_word_in] >> a_off_in;
    wire [`DPRAM_WORD_W-1:0] b_rword = mem_q[b_word_in] >> b_off_in;

    // Reset word; each lane takes only its own width of it, so no bits
    // are dropped silently when a port is narrower than a word.
    localparam [`DPRAM_WORD_W-1:0] RST_WORD = `DPRAM_DOUT_RST;

    integer i;

    // -----------------------------------------------------------------
    // Array writes
    // -----------------------------------------------------------------
    // Bit-masked writes; port B is applied last, so an overlapping
    // same-cell write leaves undefined-by-contract data.
    always @(posedge clk_in) begin
        for (i = 0; i < `DPRAM_WORD_W; i = i + 1) begin
            if (a_wr_in && a_mask_in[i]) begin
                mem_q[a_word_in][i] <= a_wdata_in[i];
            end
            if (b_wr_in && b_mask_in[i]) begin
                mem_q[b_word_in][i] <= b_wdata_in[i];
            end
        end
    end

    // -----------------------------------------------------------------
    // Output registers
    // -----------------------------------------------------------------
    // Reset beats mirror, mirror beats read; idle ports hold.
    always @(posedge clk_in) begin
        if (sys_rst_in || a_clr_in) begin
            a_dout_q <= RST_WORD[A_WIDTH-1:0];
        end else if (a_wr_in) begin
            a_dout_q <= a_data_in;
        end else if (a_rd_in) begin
            a_dout_q <= a_rword[A_WIDTH-1:0];
        end
    end

    // Port B output register, identical in form to port A.
    always @(posedge clk_in) begin
        if (sys_rst_in || b_clr_in) begin
            b_dout_q <= RST_WORD[B_WIDTH-1:0];
        end else if (b_wr_in) begin
            b_dout_q <= b_data_in;
        end else if (b_rd_in) begin
            b_dout_q <= b_rword[B_WIDTH-1:0];
        end
    end

endmodule

// ==== rtl/dpram_port.v ====
`timescale 1ns/1ps
`include "dpram_defines.vh"

// Per-port decode: turns one port's controls and address into the word
// index, bit lane mask and shifted data used by the shared array.
module dpram_port #(
    parameter WIDTH = `DPRAM_DEF_WIDTH,
    parameter LW    = 4,
    parameter AW    = 8,
    parameter MODE  = `DPRAM_MODE_RW
) (
    // Port controls, sampled on the port clock by the array.
    input  wire [AW-1:0]              addr_in,
    input  wire [WIDTH-1:0]           data_in,
    input  wire                       en_in,
    input  wire                       we_in,
    input  wire                       rst_in,
    // Decoded strobes.
    output reg                        wr_out,
    output reg                        rd_out,
    output reg                        clr_out,
    // Decoded location.
    output reg  [`DPRAM_WORD_AW-1:0]  word_out,
    output reg  [`DPRAM_WORD_LW-1:0]  off_out,
    output reg  [`DPRAM_WORD_W-1:0]   mask_out,
    output reg  [`DPRAM_WORD_W-1:0]   wdata_out
);

    // Bit address of the first cell: addr * WIDTH.
    reg [`DPRAM_CELL_AW-1:0] bitpos;

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    // Enable gates every function; a read-only port never writes.
    always @* begin
        bitpos   = {{(`DPRAM_CELL_AW-AW){1'b0}}, addr_in} << LW;
        word_out = bitpos[`DPRAM_CELL_AW-1:`DPRAM_WORD_LW];
        off_out  = bitpos[`DPRAM_WORD_LW-1:0];
        wr_out   = en_in && we_in && (MODE != `DPRAM_MODE_RO);
        // A write-only port keeps its output on reads.
        rd_out   = en_in && !wr_out && (MODE != `DPRAM_MODE_WO);
        clr_out  = en_in && rst_in;
        mask_out = {{(`DPRAM_WORD_W-WIDTH){1'b0}}, {WIDTH{1'b1}}} << off_out;
        wdata_out = {{(`DPRAM_WORD_W-WIDTH){1'b0}}, data_in} << off_out;
    end

endmodule
